// File: logic/sptx_flag_baud_data.sv
`timescale 1ns/1ps
module sptx_flag_baud_data (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [sptx_pkg::SPTX_AW+1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic xferActive,
   input wire logic rxLoad,
   input wire logic [7:0] rxByte,
   input wire logic ssIn,
   output logic shiftLoad,
   output logic [7:0] shiftData,
   output logic txIrq,
   output logic sckEdgeEn,
   output logic ssOwned,
   output logic masterMode,
   output logic unitEnable
);
   import sptx_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   logic [2:0] ctrl_reg;
   logic [1:0] rateSel_reg;
   logic faultEn_reg;
   logic txEmpty_reg;
   logic txPending_reg;
   logic modeFault_reg;
   logic modfArm_reg;
   logic rxFull_reg;
   logic ssPrev_reg;
   logic [7:0] txBuf_reg;
   logic [7:0] rxBuf_reg;
   logic [7:0] baudCnt_reg;
   logic [7:0] baudCnt_next;
   logic speBit;
   logic mstBit;
   logic setup;
   logic access;
   logic [SPTX_AW-1:0] idx;
   logic hit;
   logic ctrlWr;
   logic statWr;
   logic dataWr;
   logic statRd;
   logic dataRd;
   logic loadNow;
   logic modfSet;
   logic modfClr;
   logic baudRun;
   logic [7:0] bd;

   function automatic logic [7:0] sptx_divisor(input logic [1:0] sel);
      case (sel)
         2'h0: sptx_divisor = SPTX_BD0;
         2'h1: sptx_divisor = SPTX_BD1;
         2'h2: sptx_divisor = SPTX_BD2;
         2'h3: sptx_divisor = SPTX_BD3;
         default: sptx_divisor = SPTX_BD0;
      endcase
   endfunction : sptx_divisor

   function automatic logic sptx_mapped(input logic [SPTX_AW-1:0] i);
      sptx_mapped = (i == SPTX_IDX_CTRL) || (i == SPTX_IDX_STAT) || (i == SPTX_IDX_DATA);
   endfunction : sptx_mapped

   ////////////////////////////////////////////////////////////////////////
   // apb decode: no wait states, effects only at the completing edge
   assign speBit = ctrl_reg[SPTX_C_EN];
   assign mstBit = ctrl_reg[SPTX_C_MASTER];
   assign setup = psel && !penable;
   assign access = psel && penable && pready;
   assign idx = paddr[SPTX_AW+1:2];
   assign hit = sptx_mapped(idx) && (paddr[1:0] == 2'h0);
   assign ctrlWr = access && pwrite && hit && (idx == SPTX_IDX_CTRL);
   assign statWr = access && pwrite && hit && (idx == SPTX_IDX_STAT);
   assign dataWr = access && pwrite && hit && (idx == SPTX_IDX_DATA);
   assign statRd = access && !pwrite && hit && (idx == SPTX_IDX_STAT);
   assign dataRd = access && !pwrite && hit && (idx == SPTX_IDX_DATA);

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= setup;
         if (setup) begin
            pslverr <= !hit;
            prdata <= 32'h0;
            if (!pwrite && hit) begin
               case (idx)
                  SPTX_IDX_CTRL: prdata[2:0] <= ctrl_reg;
                  SPTX_IDX_STAT: begin
                     prdata[SPTX_S_RATE+:2] <= rateSel_reg;
                     prdata[SPTX_S_FDEN] <= faultEn_reg;
                     prdata[SPTX_S_TXE] <= txEmpty_reg;
                     prdata[SPTX_S_MODE_FAULT_FLAG] <= modeFault_reg;
                     prdata[SPTX_S_RXF] <= rxFull_reg;
                  end
                  SPTX_IDX_DATA: prdata[7:0] <= rxBuf_reg;
                  default: prdata <= 32'h0;
               endcase
            end
         end else if (!psel) begin
            pslverr <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control bits
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_reg <= SPTX_CTRL_RST;
         rateSel_reg <= SPTX_RATE_RST;
         faultEn_reg <= SPTX_FDEN_RST;
      end else begin
         if (ctrlWr) begin
            ctrl_reg <= pwdata[2:0];
         end
         if (statWr) begin
            rateSel_reg <= pwdata[SPTX_S_RATE+:2];
            faultEn_reg <= pwdata[SPTX_S_FDEN];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // data buffers carry no reset so their contents survive it
   always_ff @(posedge sys_clk) begin
      if (dataWr) begin
         txBuf_reg <= pwdata[7:0];
      end
      if (rxLoad) begin
         rxBuf_reg <= rxByte;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transmit path: load only when the engine is idle
   assign loadNow = txPending_reg && speBit && !xferActive;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         txEmpty_reg <= SPTX_TXE_RST;
         txPending_reg <= 1'b0;
         shiftLoad <= 1'b0;
         shiftData <= 8'h0;
      end else begin
         shiftLoad <= loadNow;
         if (loadNow) begin
            shiftData <= txBuf_reg;
         end
         // a write landing with a load keeps the new byte pending
         if (dataWr) begin
            txPending_reg <= 1'b1;
            txEmpty_reg <= 1'b0;
         end else if (loadNow) begin
            txPending_reg <= 1'b0;
            txEmpty_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         txIrq <= 1'b0;
      end else begin
         txIrq <= txEmpty_reg && ctrl_reg[SPTX_C_TXIE];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // mode fault; master ignores select unless detection is on
   assign modfSet = faultEn_reg && speBit
      && ((!mstBit && xferActive && ssIn && !ssPrev_reg) || (mstBit && !ssIn));
   assign modfClr = ctrlWr && modfArm_reg;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         modeFault_reg <= 1'b0;
         modfArm_reg <= 1'b0;
         ssPrev_reg <= 1'b1;
      end else begin
         ssPrev_reg <= ssIn;
         // set wins over clear; enable bit never clears the flag
         if (modfSet) begin
            modeFault_reg <= 1'b1;
         end else if (modfClr) begin
            modeFault_reg <= 1'b0;
         end
         if (statRd && modeFault_reg) begin
            modfArm_reg <= 1'b1;
         end else if (ctrlWr) begin
            modfArm_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rxFull_reg <= 1'b0;
      end else if (rxLoad) begin
         rxFull_reg <= 1'b1;
      end else if (dataRd) begin
         rxFull_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ssOwned <= 1'b0;
         masterMode <= 1'b1;
         unitEnable <= 1'b0;
      end else begin
         ssOwned <= speBit && (!mstBit || faultEn_reg);
         masterMode <= mstBit;
         unitEnable <= speBit;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // serial clock edge enable: one pulse per half period of bd cycles
   assign baudRun = speBit && mstBit;
   assign bd = sptx_divisor(rateSel_reg);
   assign baudCnt_next = (!baudRun || baudCnt_reg >= bd - 8'h1) ? 8'h0 : baudCnt_reg + 8'h1;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         baudCnt_reg <= 8'h0;
         sckEdgeEn <= 1'b0;
      end else begin
         baudCnt_reg <= baudCnt_next;
         sckEdgeEn <= baudRun && (baudCnt_reg >= bd - 8'h1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   load_sets_empty_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      shiftLoad |-> txEmpty_reg)
      else $error("empty flag not set after shift load");

   irq_gate_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      txIrq |-> $past(txEmpty_reg) && $past(ctrl_reg[SPTX_C_TXIE]))
      else $error("transmit irq without enabled empty flag");

   idle_refill_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (dataWr && speBit && !xferActive) ##1 !xferActive |=> txEmpty_reg && shiftLoad)
      else $error("idle unit did not refill within two cycles");

   busy_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      xferActive && txPending_reg |=> !shiftLoad && !txEmpty_reg)
      else $error("shift load during active transfer");

   write_clears_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      dataWr |=> !txEmpty_reg && txBuf_reg == $past(pwdata[7:0]))
      else $error("data write did not clear empty or load buffer");

   fault_gate_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      $rose(modeFault_reg) |-> $past(faultEn_reg))
      else $error("mode fault set while detection disabled");

   fault_keep_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      modeFault_reg && !modfClr |=> modeFault_reg)
      else $error("mode fault cleared without clear sequence");

   ss_owner_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (speBit && !mstBit) |=> ssOwned)
      else $error("enabled slave lost slave-select");

   slave_noclk_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      !mstBit |=> !sckEdgeEn)
      else $error("serial clock enable in slave mode");

   baud_eight_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (sckEdgeEn && baudRun && rateSel_reg == 2'h1)
      ##1 (baudRun && rateSel_reg == 2'h1)[*8] |-> sckEdgeEn && $past(!sckEdgeEn))
      else $error("divisor eight period wrong");

   rx_read_clr_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      dataRd && !rxLoad |=> !rxFull_reg)
      else $error("data read did not clear receive-full");

   reset_values_a: assert property (@(posedge sys_clk)
      $rose(resetn) |-> txEmpty_reg && rateSel_reg == SPTX_RATE_RST && !faultEn_reg)
      else $error("wrong state after reset release");

   baud_two_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (sckEdgeEn && baudRun && rateSel_reg == 2'h0)
      ##1 (baudRun && rateSel_reg == 2'h0 && !sckEdgeEn) |=> sckEdgeEn)
      else $error("divisor two period wrong");

   ss_free_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      speBit && mstBit && !faultEn_reg |=> !ssOwned && !$rose(modeFault_reg))
      else $error("master without detection took slave-select");

   ss_taken_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      speBit && faultEn_reg |=> ssOwned)
      else $error("detection on but slave-select not owned");

   ss_idle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      !speBit |=> !ssOwned)
      else $error("disabled unit kept slave-select");

   data_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      dataRd |-> prdata == {24'h0, $past(rxBuf_reg)})
      else $error("data read not from receive buffer");

   load_data_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      shiftLoad |-> shiftData == $past(txBuf_reg))
      else $error("shift load carried wrong byte");

   empty_source_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      $rose(txEmpty_reg) |-> shiftLoad)
      else $error("empty flag set without a shift load");

   irq_raise_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      txEmpty_reg && ctrl_reg[SPTX_C_TXIE] |=> txIrq)
      else $error("enabled empty flag raised no irq");

   fault_master_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      faultEn_reg && speBit && mstBit && !ssIn |=> modeFault_reg)
      else $error("master select low did not set mode fault");

   fault_slave_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      faultEn_reg && speBit && !mstBit && xferActive && $rose(ssIn) |=> modeFault_reg)
      else $error("slave select rise did not set mode fault");

endmodule : sptx_flag_baud_data

// File: logic/sptx_pkg.sv
package sptx_pkg;
   // word indices; byte address is four times the index
   localparam logic [7:0] SPTX_IDX_CTRL = 8'h10;
   localparam logic [7:0] SPTX_IDX_STAT = 8'h11;
   localparam logic [7:0] SPTX_IDX_DATA = 8'h12;
   localparam int SPTX_AW = 8;
   // control word fields
   localparam int SPTX_C_EN = 0;
   localparam int SPTX_C_MASTER = 1;
   localparam int SPTX_C_TXIE = 2;
   localparam logic [2:0] SPTX_CTRL_RST = 3'h2;
   // status and control word fields
   localparam int SPTX_S_RATE = 0;
   localparam int SPTX_S_FDEN = 2;
   localparam int SPTX_S_TXE = 3;
   localparam int SPTX_S_MODE_FAULT_FLAG = 4;
   localparam int SPTX_S_RXF = 7;
   localparam logic [1:0] SPTX_RATE_RST = 2'h0;
   localparam logic SPTX_FDEN_RST = 1'b0;
   localparam logic SPTX_TXE_RST = 1'b1;
   // baud divisors per rate-select code
   localparam logic [7:0] SPTX_BD0 = 8'h02;
   localparam logic [7:0] SPTX_BD1 = 8'h08;
   localparam logic [7:0] SPTX_BD2 = 8'h20;
   localparam logic [7:0] SPTX_BD3 = 8'h80;
endpackage : sptx_pkg

// File: dv/sptx_remote.sv
`timescale 1ns/1ps
module sptx_remote (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic shiftLoad,
   input wire logic [7:0] shiftData,
   input wire logic [7:0] busyLen,
   input wire logic ssLevel,
   output logic xferActive,
   output logic rxLoad,
   output logic [7:0] rxByte,
   output logic ssIn
);
   logic [7:0] cnt;
   logic [7:0] held;
   assign ssIn = ssLevel;
   // busyLen sets a prompt or slow partner; answer is the inverted byte
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt <= 8'h00;
         xferActive <= 1'b0;
         rxLoad <= 1'b0;
         rxByte <= 8'h00;
         held <= 8'h00;
      end else begin
         rxLoad <= 1'b0;
         // byte lane is not valid outside rxLoad, so keep it moving
         rxByte <= ~rxByte;
         if (shiftLoad) begin
            held <= ~shiftData;
            cnt <= busyLen;
            xferActive <= 1'b1;
         end else if (cnt > 8'h01) begin
            cnt <= cnt - 8'h01;
         end else if (xferActive) begin
            xferActive <= 1'b0;
            rxLoad <= 1'b1;
            rxByte <= held;
         end
      end
   end
endmodule : sptx_remote

// File: dv/tb.sv
`timescale 1ns/1ps
module tb;
   import sptx_pkg::*;
   logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr, lastErr;
   logic [SPTX_AW+1:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic xferActive, rxLoad, ssIn, shiftLoad, txIrq, sckEdgeEn, ssOwned, ssLevel;
   logic masterMode, unitEnable;
   logic [7:0] rxByte, shiftData, busyLen, b0, b1;
   int failures, n_tests, seed, n, k;
   sptx_flag_baud_data sptx_flag_baud_data_i (.sys_clk(sys_clk), .resetn(resetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .xferActive(xferActive),
      .rxLoad(rxLoad), .rxByte(rxByte), .ssIn(ssIn), .shiftLoad(shiftLoad),
      .shiftData(shiftData), .txIrq(txIrq), .sckEdgeEn(sckEdgeEn), .ssOwned(ssOwned),
      .masterMode(masterMode), .unitEnable(unitEnable));
   sptx_remote sptx_remote_i (.sys_clk(sys_clk), .resetn(resetn), .shiftLoad(shiftLoad),
      .shiftData(shiftData), .busyLen(busyLen), .ssLevel(ssLevel),
      .xferActive(xferActive), .rxLoad(rxLoad), .rxByte(rxByte), .ssIn(ssIn));
   always #50 sys_clk = ~sys_clk;
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] stat(int r, fd, te, mf, rf);
      return {24'h0, rf[0], 2'b00, mf[0], te[0], fd[0], r[1:0]};
   endfunction : stat
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   // idle cycle after each transfer so psel never toggles twice in one step
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      for (int i = 0; i < 50; i++) begin
         @(posedge sys_clk);
         if (pready === 1'b1) break;
      end
      if (pready !== 1'b1) begin
         failures++;
         $display("[ERR] %0t no pready", $time);
      end
      rdv = prdata;
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb
   task automatic waitLoad(int lim);
      for (n = 0; n < lim; n++) begin
         @(posedge sys_clk);
         if (shiftLoad === 1'b1) break;
      end
      if (n >= lim) begin
         failures++;
         $display("[ERR] %0t no shift load", $time);
      end
   endtask : waitLoad
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (30000) @(posedge sys_clk);
      failures++;
      give_verdict();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 0; resetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
      pwdata = '0; busyLen = 8'h0c; ssLevel = 1; failures = 0; n_tests = 0; seed = 47;
      repeat (20) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      apb(0, SPTX_IDX_STAT, 0); chk(rdv, stat(0, 0, 1, 0, 0), "stat reset");
      apb(0, SPTX_IDX_CTRL, 0); chk(rdv, {29'h0, SPTX_CTRL_RST}, "ctrl reset");
      apb(0, 8'h13, 0); chk({31'h0, lastErr}, 1, "unmapped");
      for (k = 0; k < 3; k++) begin
         b0 = 8'($random(seed));
         b1 = 8'($random(seed));
         busyLen <= 8'h0a + 8'($random(seed) & 7);
         apb(1, SPTX_IDX_CTRL, 32'h07);
         apb(1, SPTX_IDX_DATA, {24'h0, b0});
         waitLoad(4); chk(shiftData, b0, "first load");
         chk({31'h0, n < 2}, 1, "idle load late");
         apb(1, SPTX_IDX_DATA, {24'h0, b1});
         apb(0, SPTX_IDX_STAT, 0); chk(rdv[3], 0, "empty while queued");
         chk(txIrq, 0, "irq without empty");
         waitLoad(40); chk(shiftData, b1, "second load");
         repeat (2) @(posedge sys_clk);
         chk(txIrq, 1, "irq on empty");
         apb(1, SPTX_IDX_CTRL, 32'h03);
         // irq follows the enable one cycle late
         @(posedge sys_clk);
         chk(txIrq, 0, "irq masked");
         while (xferActive === 1'b1) @(posedge sys_clk);
         repeat (2) @(posedge sys_clk);
         apb(0, SPTX_IDX_STAT, 0); chk(rdv, stat(0, 0, 1, 0, 1), "rx full");
         apb(0, SPTX_IDX_DATA, 0); chk(rdv, {24'h0, ~b1}, "rx buffer");
         apb(0, SPTX_IDX_STAT, 0); chk(rdv[7], 0, "rx full cleared");
      end
      busyLen <= 8'h1e;
      apb(1, SPTX_IDX_CTRL, 32'h01);
      apb(1, SPTX_IDX_DATA, {24'h0, b0});
      apb(1, SPTX_IDX_DATA, {24'h0, b1});
      apb(0, SPTX_IDX_STAT, 0); chk(rdv[3], 0, "slave busy holds");
      waitLoad(60); chk(shiftData, b1, "slave late load");
      for (k = 0; k < 4; k++) begin
         apb(1, SPTX_IDX_STAT, k);
         apb(1, SPTX_IDX_CTRL, 32'h03);
         while (sckEdgeEn !== 1'b1) @(posedge sys_clk);
         for (n = 1; n < 300; n++) begin
            @(posedge sys_clk);
            if (sckEdgeEn === 1'b1) break;
         end
         chk(n, 2 << (2 * k), "divisor");
      end
      apb(1, SPTX_IDX_CTRL, 32'h01);
      @(posedge sys_clk);
      for (n = 0; n < 300 && sckEdgeEn !== 1'b1; n++) @(posedge sys_clk);
      chk(n, 300, "slave rate");
      apb(1, SPTX_IDX_STAT, 0);
      apb(1, SPTX_IDX_CTRL, 32'h03);
      ssLevel <= 1'b0;
      apb(0, SPTX_IDX_STAT, 0); chk(rdv[4], 0, "fault gated");
      chk({ssOwned, masterMode}, 2'b01, "pin free");
      apb(1, SPTX_IDX_STAT, 32'h04);
      apb(0, SPTX_IDX_STAT, 0); chk(rdv[4], 1, "master fault");
      chk(ssOwned, 1, "pin taken");
      ssLevel <= 1'b1;
      apb(1, SPTX_IDX_STAT, 0);
      apb(0, SPTX_IDX_STAT, 0); chk(rdv[4], 1, "fault kept");
      apb(1, SPTX_IDX_CTRL, 32'h01);
      apb(0, SPTX_IDX_STAT, 0); chk(rdv[4], 0, "fault cleared");
      chk({ssOwned, masterMode, unitEnable}, 3'b101, "slave pin");
      // slave fault: select pulses low in the middle of a transfer
      apb(1, SPTX_IDX_STAT, 32'h04);
      apb(1, SPTX_IDX_DATA, {24'h0, b0});
      repeat (2) @(posedge sys_clk);
      ssLevel <= 1'b0;
      @(posedge sys_clk);
      ssLevel <= 1'b1;
      @(posedge sys_clk);
      apb(0, SPTX_IDX_STAT, 0); chk(rdv[4], 1, "slave fault");
      while (xferActive === 1'b1) @(posedge sys_clk);
      @(posedge sys_clk);
      resetn <= 1'b0;
      @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      apb(0, SPTX_IDX_STAT, 0); chk(rdv, stat(0, 0, 1, 0, 0), "stat after reset");
      apb(0, SPTX_IDX_DATA, 0); chk(rdv, {24'h0, ~b0}, "data kept");
      give_verdict();
   end
endmodule : tb
